// ==== tmo_pkg.sv ====
// constants shared by the timer overflow and output control block
package tmo_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_CTRL_STATUS = 4'h0;
  localparam logic [3:0] OFS_CONST_A = 4'h1;
  localparam logic [3:0] OFS_CONST_B = 4'h2;
  localparam logic [3:0] OFS_TIMER_COUNT = 4'h3;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h5;

  // ----------------------------------------------------------------
  // control/status field positions and reset values
  // ----------------------------------------------------------------
  localparam int POS_WRAP_FLAG = 5;
  localparam int POS_RESERVED = 4;
  localparam int POS_SEL_B_HI = 3;
  localparam int POS_SEL_B_LO = 2;
  localparam int POS_SEL_A_HI = 1;
  localparam int POS_SEL_A_LO = 0;
  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [7:0] RST_CONST = 8'hFF;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic RST_OUT_LEVEL = 1'b0;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_N = 3;
  localparam int POS_IRQ_WRAP = 0;
  localparam int POS_IRQ_MATCH_A = 1;
  localparam int POS_IRQ_MATCH_B = 2;
  localparam logic [2:0] RST_IRQ = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_KEEP = 2'b00,
    SEL_LOW = 2'b01,
    SEL_HIGH = 2'b10,
    SEL_TOGGLE = 2'b11
  } tmo_sel_t;

  typedef enum logic {
    CLR_IDLE = 1'b0,
    CLR_ARMED = 1'b1
  } tmo_clr_t;

endpackage

// ==== tmo_out_unit.sv ====
// timer output level driven by compare-match actions
`timescale 1ns/10ps
module tmo_out_unit
  import tmo_pkg::*;
(
  // clock, reset and enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // match events and selects
  input wire logic match_a,
  input wire logic match_b,
  input wire logic [1:0] sel_a,
  input wire logic [1:0] sel_b,
  // pin level
  output logic out_level
);

  logic out_level_ff;
  logic nxt_out_level;
  logic after_b;

  function automatic logic apply_sel(input logic cur, input logic [1:0] sel);
    logic res;
    res = cur;
    unique case (tmo_sel_t'(sel))
      SEL_KEEP: res = cur;
      SEL_LOW: res = 1'b0;
      SEL_HIGH: res = 1'b1;
      SEL_TOGGLE: res = ~cur;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // actions: b first, then a on top, so a has the last word
  // ----------------------------------------------------------------
  assign after_b = match_b ? apply_sel(out_level_ff, sel_b) : out_level_ff; // RULE5 RULE8
  assign nxt_out_level = match_a ? apply_sel(after_b, sel_a) : after_b; // RULE6 RULE8

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_level_ff <= RST_OUT_LEVEL;
    end else if (ce) begin
      out_level_ff <= nxt_out_level;
    end
  end

  assign out_level = out_level_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_match_b_low: assert property (ce && match_b && !match_a && sel_b == 2'b01 |=> !out_level) // RULE5
    else $error("match b with low select did not drive low");
  chk_match_b_toggle: assert property (ce && match_b && !match_a && sel_b == 2'b11 |=> out_level != $past(out_level)) // RULE5
    else $error("match b toggle did not invert");
  chk_match_a_high: assert property (ce && match_a && sel_a == 2'b10 |=> out_level) // RULE6
    else $error("match a with high select did not drive high");
  chk_match_a_keep: assert property (ce && match_a && !match_b && sel_a == 2'b00 |=> $stable(out_level)) // RULE6
    else $error("match a with keep select changed the output");
  chk_a_after_b: assert property (ce && match_a && match_b && sel_a == 2'b01 && sel_b == 2'b10 |=> !out_level) // RULE8
    else $error("match a did not take effect after match b");

endmodule

// ==== tmo_timer8.sv ====
// 8-bit timer channel: count, wrap flag, compare matches, output pin
`timescale 1ns/10ps
// What this block does
// RULE1 - set the wrap flag when the count rolls from its maximum to zero.
// RULE2 - flag clears only by reading it as one, then writing zero.
// RULE3 - writing one to the wrap flag never sets it.
// RULE4 - software writes zero to reserved bit 4; it stays readable and writable.
// RULE5 - match b applies its select: keep, low, high or toggle.
// RULE6 - match a applies its select: keep, low, high or invert.
// RULE7 - wrap flag sits at bit 5, resets to zero, sets on the wrap transition.
// RULE8 - matches fire once when the count arrives at its constant; a acts after b.
module tmo_timer8
  import tmo_pkg::*;
(
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // count advance from same-clock prescaler
  input wire logic count_tick,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // timer output pin and interrupt
  output logic timer_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] timer_count_ff;
  logic [7:0] nxt_timer_count;
  logic [7:0] compare_const_a_ff;
  logic [7:0] compare_const_b_ff;
  logic count_wrap_flag_ff;
  logic nxt_count_wrap_flag;
  logic reserved_ff;
  logic match_b_out_sel_hi_ff;
  logic match_b_out_sel_lo_ff;
  logic match_a_out_sel_hi_ff;
  logic match_a_out_sel_lo_ff;
  tmo_clr_t clr_state_ff;
  tmo_clr_t nxt_clr_state;
  logic count_moved_ff;
  logic [2:0] irq_status_ff;
  logic [2:0] nxt_irq_status;
  logic [2:0] irq_mask_ff;
  logic [2:0] irq_events;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] ctrl_status_view;
  logic sel_ctrl;
  logic sel_const_a;
  logic sel_const_b;
  logic sel_count;
  logic sel_irq_status;
  logic sel_irq_mask;
  logic wr_ctrl;
  logic rd_ctrl;
  logic wr_count;
  logic wrap_evt;
  logic clear_req;
  logic match_a;
  logic match_b;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign sel_ctrl = (addr == OFS_CTRL_STATUS);
  assign sel_const_a = (addr == OFS_CONST_A);
  assign sel_const_b = (addr == OFS_CONST_B);
  assign sel_count = (addr == OFS_TIMER_COUNT);
  assign sel_irq_status = (addr == OFS_IRQ_STATUS);
  assign sel_irq_mask = (addr == OFS_IRQ_MASK);
  assign wr_ctrl = wr && sel_ctrl;
  assign rd_ctrl = rd && sel_ctrl;
  assign wr_count = wr && sel_count;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // a software write to the count beats a tick in the same cycle
  assign wrap_evt = count_tick && !wr_count && (timer_count_ff == COUNT_MAX); // RULE1
  assign nxt_timer_count = wr_count ? wdata :
                           count_tick ? timer_count_ff + COUNT_ONE : timer_count_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_count_ff <= RST_COUNT;
      count_moved_ff <= 1'b0;
    end else if (ce) begin
      timer_count_ff <= nxt_timer_count;
      count_moved_ff <= count_tick || wr_count;
    end
  end

  // ----------------------------------------------------------------
  // compare constants and matches
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      compare_const_a_ff <= RST_CONST;
      compare_const_b_ff <= RST_CONST;
    end else if (ce) begin
      if (wr && sel_const_a) begin
        compare_const_a_ff <= wdata;
      end
      if (wr && sel_const_b) begin
        compare_const_b_ff <= wdata;
      end
    end
  end

  // one match per arrival of the count, so a stalled count does not keep toggling
  assign match_a = count_moved_ff && (timer_count_ff == compare_const_a_ff); // RULE8
  assign match_b = count_moved_ff && (timer_count_ff == compare_const_b_ff); // RULE8

  // ----------------------------------------------------------------
  // wrap flag clear sequence: read as one arms, write zero clears
  // ----------------------------------------------------------------
  always_comb begin
    nxt_clr_state = clr_state_ff;
    unique case (clr_state_ff)
      CLR_IDLE: begin
        if (rd_ctrl && count_wrap_flag_ff) begin
          nxt_clr_state = CLR_ARMED; // RULE2
        end
      end
      CLR_ARMED: begin
        if (wr_ctrl) begin
          nxt_clr_state = CLR_IDLE;
        end
      end
    endcase
  end

  assign clear_req = (clr_state_ff == CLR_ARMED) && wr_ctrl && !wdata[POS_WRAP_FLAG]; // RULE2
  // a wrap in the clearing cycle wins; a written one is never a set
  assign nxt_count_wrap_flag = wrap_evt ? 1'b1 :
                               clear_req ? 1'b0 : count_wrap_flag_ff; // RULE3 RULE7

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clr_state_ff <= CLR_IDLE;
      count_wrap_flag_ff <= RST_CTRL_STATUS[POS_WRAP_FLAG]; // RULE7
    end else if (ce) begin
      clr_state_ff <= nxt_clr_state;
      count_wrap_flag_ff <= nxt_count_wrap_flag; // RULE1
    end
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reserved_ff <= RST_CTRL_STATUS[POS_RESERVED];
      match_b_out_sel_hi_ff <= RST_CTRL_STATUS[POS_SEL_B_HI];
      match_b_out_sel_lo_ff <= RST_CTRL_STATUS[POS_SEL_B_LO];
      match_a_out_sel_hi_ff <= RST_CTRL_STATUS[POS_SEL_A_HI];
      match_a_out_sel_lo_ff <= RST_CTRL_STATUS[POS_SEL_A_LO];
    end else if (ce && wr_ctrl) begin
      reserved_ff <= wdata[POS_RESERVED]; // RULE4
      match_b_out_sel_hi_ff <= wdata[POS_SEL_B_HI];
      match_b_out_sel_lo_ff <= wdata[POS_SEL_B_LO];
      match_a_out_sel_hi_ff <= wdata[POS_SEL_A_HI];
      match_a_out_sel_lo_ff <= wdata[POS_SEL_A_LO];
    end
  end

  assign ctrl_status_view = {2'b00, count_wrap_flag_ff, reserved_ff,
                             match_b_out_sel_hi_ff, match_b_out_sel_lo_ff,
                             match_a_out_sel_hi_ff, match_a_out_sel_lo_ff};

  // ----------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------
  tmo_out_unit u_out (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .match_a(match_a),
    .match_b(match_b),
    .sel_a({match_a_out_sel_hi_ff, match_a_out_sel_lo_ff}),
    .sel_b({match_b_out_sel_hi_ff, match_b_out_sel_lo_ff}),
    .out_level(timer_out)
  );

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  assign irq_events[POS_IRQ_WRAP] = wrap_evt;
  assign irq_events[POS_IRQ_MATCH_A] = match_a;
  assign irq_events[POS_IRQ_MATCH_B] = match_b;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
      assign nxt_irq_status[gi] = irq_events[gi] ||
                                  (irq_status_ff[gi] && !(wr && sel_irq_status && wdata[gi]));
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status_ff <= RST_IRQ;
      irq_mask_ff <= RST_IRQ;
    end else if (ce) begin
      irq_status_ff <= nxt_irq_status;
      if (wr && sel_irq_mask) begin
        irq_mask_ff <= wdata[2:0];
      end
    end
  end

  assign irq = |(irq_status_ff & irq_mask_ff);

  // ----------------------------------------------------------------
  // read data, valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  assign nxt_rdata = !rd ? 8'h00 :
                     sel_ctrl ? ctrl_status_view :
                     sel_const_a ? compare_const_a_ff :
                     sel_const_b ? compare_const_b_ff :
                     sel_count ? timer_count_ff :
                     sel_irq_status ? {5'b0_0000, irq_status_ff} :
                     sel_irq_mask ? {5'b0_0000, irq_mask_ff} : 8'h00;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_read_flag_one;
    ce && rd_ctrl && count_wrap_flag_ff;
  endsequence

  sequence s_write_zero;
    ce && wr_ctrl && !wdata[POS_WRAP_FLAG] && !wrap_evt;
  endsequence

  chk_wrap_sets_flag: assert property (ce && wrap_evt |=> count_wrap_flag_ff) // RULE1
    else $error("wrap did not set the flag");
  chk_read_write_clear: assert property (s_read_flag_one ##1 s_write_zero |=> !count_wrap_flag_ff) // RULE2
    else $error("read-one then write-zero did not clear the flag");
  chk_flag_fall_cause: assert property ($fell(count_wrap_flag_ff) |-> $past(clear_req)) // RULE2
    else $error("flag cleared without the read-write sequence");
  chk_write_one_no_set: assert property (ce && wr_ctrl && wdata[POS_WRAP_FLAG] && !wrap_evt
                                         && !count_wrap_flag_ff |=> !count_wrap_flag_ff) // RULE3
    else $error("writing one set the wrap flag");
  chk_reserved_rw: assert property (ce && wr_ctrl ##1 ce && rd_ctrl
                                    |=> rdata[POS_RESERVED] == $past(wdata[POS_RESERVED], 2)) // RULE4
    else $error("reserved bit not readable as written");
  chk_flag_at_wrap: assert property (ce && count_tick && !wr_count && timer_count_ff == COUNT_MAX
                                     |=> timer_count_ff == 8'h00 && irq_status_ff[POS_IRQ_WRAP]
                                         && count_wrap_flag_ff) // RULE7
    else $error("flag not set at the wrap transition");
  chk_match_a_fires: assert property (ce && count_tick && !wr_count
                                      && nxt_timer_count == compare_const_a_ff && !(wr && sel_const_a)
                                      |=> match_a) // RULE8
    else $error("match a missing when count reached constant");
  chk_irq_level: assert property (ce && wrap_evt && irq_mask_ff[POS_IRQ_WRAP] && !(wr && sel_irq_mask) |=> irq)
    else $error("interrupt status or output wrong");

endmodule

// ==== tmo_timer8_bench.sv ====
// self-checking bench for the 8-bit timer overflow and output control block
`timescale 1ns/10ps
module tmo_timer8_bench
  import tmo_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic count_tick = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic timer_out;
  logic irq;
  int mismatches = 0;
  int n_compared = 0;
  logic exp_out = RST_OUT_LEVEL;

  always #20 clock = ~clock;

  tmo_timer8 i_dut (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .count_tick(count_tick),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .timer_out(timer_out),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    n_compared++;
    if (seen !== expv) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // strobes drop at the taking edge, then step off it so the next call never re-drives in that step
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic tick();
    count_tick <= 1'b1;
    @(posedge clock);
    count_tick <= 1'b0;
    #1;
  endtask

  function automatic logic apply_sel(input logic lvl, input logic [1:0] sel);
    case (sel)
      SEL_KEEP: apply_sel = lvl;
      SEL_LOW: apply_sel = 1'b0;
      SEL_HIGH: apply_sel = 1'b1;
      default: apply_sel = ~lvl;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] v;
    logic [7:0] rst_tab [0:6];
    rst_tab = '{RST_CTRL_STATUS, RST_CONST, RST_CONST, RST_COUNT, 8'h00, 8'h00, 8'h00};
    wr_reg(4'h6, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      rd_reg(4'(i), v);
      check(v, rst_tab[i]);
    end
    check({7'h00, timer_out}, {7'h00, RST_OUT_LEVEL});
    check({7'h00, irq}, 8'h00);
  endtask

  task automatic t_reserved_bit();
    logic [7:0] v;
    // software keeps the reserved bit at zero; the other bits prove the write lands
    wr_reg(OFS_CTRL_STATUS, 8'h0F);
    rd_reg(OFS_CTRL_STATUS, v);
    check(v, 8'h0F);
    wr_reg(OFS_CTRL_STATUS, 8'h00);
    rd_reg(OFS_CTRL_STATUS, v);
    check(v, 8'h00);
    // a frozen block takes no write
    ce <= 1'b0;
    wr_reg(OFS_CTRL_STATUS, 8'h0F);
    ce <= 1'b1;
    rd_reg(OFS_CTRL_STATUS, v);
    check(v, 8'h00);
  endtask

  // one count arrival per step; the level is judged one edge after the count arrives
  task automatic match_step(input logic [7:0] ctrl, input logic [7:0] pre, input logic [1:0] sb,
                            input logic [1:0] sa);
    wr_reg(OFS_CTRL_STATUS, ctrl);
    wr_reg(OFS_TIMER_COUNT, pre);
    tick();
    @(posedge clock);
    #1;
    exp_out = apply_sel(apply_sel(exp_out, sb), sa);
  endtask

  task automatic t_match_outputs();
    logic [1:0] seq [0:4];
    seq = '{SEL_HIGH, SEL_KEEP, SEL_LOW, SEL_TOGGLE, SEL_TOGGLE};
    wr_reg(OFS_CONST_A, 8'h05);
    wr_reg(OFS_CONST_B, 8'h09);
    for (int i = 0; i < 5; i++) begin
      match_step({6'h00, seq[i]}, 8'h04, SEL_KEEP, seq[i]);
      check({7'h00, timer_out}, {7'h00, exp_out});
      match_step({4'h0, seq[i], 2'b00}, 8'h08, seq[i], SEL_KEEP);
      check({7'h00, timer_out}, {7'h00, exp_out});
    end
    // both together: b drives high, then a inverts it
    wr_reg(OFS_CONST_A, 8'h0C);
    wr_reg(OFS_CONST_B, 8'h0C);
    match_step(8'h0B, 8'h0B, SEL_HIGH, SEL_TOGGLE);
    check({7'h00, timer_out}, 8'h00);
    check({7'h00, timer_out}, {7'h00, exp_out});
  endtask

  task automatic t_wrap_flag();
    logic [7:0] v;
    wr_reg(OFS_CTRL_STATUS, 8'h00);
    wr_reg(OFS_IRQ_STATUS, 8'h07);
    wr_reg(OFS_TIMER_COUNT, COUNT_MAX);
    tick();
    rd_reg(OFS_IRQ_STATUS, v);
    check(v, 8'h01);
    check({7'h00, irq}, 8'h00);
    wr_reg(OFS_IRQ_MASK, 8'h01);
    check({7'h00, irq}, 8'h01);
    // a zero written before any read of one must not clear
    wr_reg(OFS_CTRL_STATUS, 8'h00);
    rd_reg(OFS_CTRL_STATUS, v);
    check(v, 8'h20);
    rd_reg(OFS_TIMER_COUNT, v);
    check(v, 8'h00);
    // writing one after the arming read neither clears nor sets
    wr_reg(OFS_CTRL_STATUS, 8'h20);
    rd_reg(OFS_CTRL_STATUS, v);
    check(v, 8'h20);
    wr_reg(OFS_CTRL_STATUS, 8'h00);
    rd_reg(OFS_CTRL_STATUS, v);
    check(v, 8'h00);
    wr_reg(OFS_CTRL_STATUS, 8'h20);
    rd_reg(OFS_CTRL_STATUS, v);
    check(v, 8'h00);
    // interrupt: masked, unmasked, cleared by writing one
    wr_reg(OFS_IRQ_MASK, 8'h00);
    check({7'h00, irq}, 8'h00);
    wr_reg(OFS_IRQ_MASK, 8'h01);
    wr_reg(OFS_IRQ_STATUS, 8'h01);
    check({7'h00, irq}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    t_reset_values();
    t_reserved_bit();
    t_match_outputs();
    t_wrap_flag();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    conclude();
  end
endmodule
